// [bench/opsf_load.sv]
// Model of the external loads on the port: a pull-up resistor on every pin.
module opsf_load (
  input  wire logic [19:0] pin_i,
  input  wire logic [19:0] pin_oe_i,
  output logic      [19:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released or floating pin is pulled high, which open-drain drivers rely on.
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      level_o[i] = pin_oe_i[i] ? pin_i[i] : 1'b1;
    end
  end
endmodule

// [bench/tb.sv]
// Self-checking testbench for the special-function output port over APB.
module tb;
  import opsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Half period of the slow oscillator in ns; the clock-pair checks are reckoned from it.
  localparam int LF_HALF = 520;

  logic               clk_i       = 1'b0;
  logic               arst_n_i    = 1'b0;
  logic               psel_i      = 1'b0;
  logic               penable_i   = 1'b0;
  logic               pwrite_i    = 1'b0;
  logic [PADDR_W-1:0] paddr_i     = '0;
  logic [31:0]        pwdata_i    = 32'h0;
  logic               buzzer_i    = 1'b0;
  logic               serial_ready_out_i      = 1'b0;
  logic               tclk_i      = 1'b0;
  logic               hf_i        = 1'b0;
  logic               lf_i        = 1'b0;
  logic [31:0]        prdata_o;
  logic               pready_o;
  logic               pslverr_o;
  logic [2:0]         tsel_o;
  logic [19:0]        pin_o;
  logic [19:0]        pin_oe_o;
  logic [19:0]        level_o;
  logic [31:0]        rdata;
  logic               rerr;
  logic [3:0]         pat [4] = '{4'hA, 4'h5, 4'hC, 4'h6};
  int                 err_total   = 0;
  int                 checked     = 0;
  logic [19:0]        pin_b;
  logic [19:0]        pin_oe_b;
  time                t0;

  // Buzzer pair plus timer clock; group one is open-drain as a whole group.
  opsf_port #(
    .G3_OPT      (OPSF_G3_TCLK),
    .G3_TWO_STATE(1'b0),
    .G4_BUZZ_OPT (1'b1),
    .G42_OPT     (OPSF_G42_IBUZ),
    .G40_ICLK_OPT(1'b0),
    .CLK_SRC     (4'h1),
    .OPEN_DRAIN  (20'h000F0)
  ) opsf_port_inst (
    .clk_i                (clk_i),
    .arst_n_i             (arst_n_i),
    .psel_i               (psel_i),
    .penable_i            (penable_i),
    .pwrite_i             (pwrite_i),
    .paddr_i              (paddr_i),
    .pwdata_i             (pwdata_i),
    .prdata_o             (prdata_o),
    .pready_o             (pready_o),
    .pslverr_o            (pslverr_o),
    .buzzer_i             (buzzer_i),
    .serial_ready_i       (serial_ready_out_i),
    .timer_clock_i        (tclk_i),
    .timer_clock_select_o (tsel_o),
    .high_freq_osc_clock_i(hf_i),
    .low_freq_osc_clock_i (lf_i),
    .pin_o                (pin_o),
    .pin_oe_o             (pin_oe_o)
  );

  // Second build on the same bus: serial ready on a two-state pin and the slow clock halved
  // onto the clock pair; it only answers through its pins.
  opsf_port #(
    .G3_OPT      (OPSF_G3_SERIAL_READY_OUT),
    .G3_TWO_STATE(1'b1),
    .G4_BUZZ_OPT (1'b0),
    .G42_OPT     (OPSF_G42_CLK),
    .G40_ICLK_OPT(1'b1),
    .CLK_SRC     (4'h2),
    .OPEN_DRAIN  (20'h00000)
  ) opsf_port_inst2 (
    .clk_i                (clk_i),
    .arst_n_i             (arst_n_i),
    .psel_i               (psel_i),
    .penable_i            (penable_i),
    .pwrite_i             (pwrite_i),
    .paddr_i              (paddr_i),
    .pwdata_i             (pwdata_i),
    .prdata_o             (),
    .pready_o             (),
    .pslverr_o            (),
    .buzzer_i             (buzzer_i),
    .serial_ready_i       (serial_ready_out_i),
    .timer_clock_i        (tclk_i),
    .timer_clock_select_o (),
    .high_freq_osc_clock_i(hf_i),
    .low_freq_osc_clock_i (lf_i),
    .pin_o                (pin_b),
    .pin_oe_o             (pin_oe_b)
  );

  opsf_load opsf_load_inst (
    .pin_i   (pin_o),
    .pin_oe_i(pin_oe_o),
    .level_o (level_o)
  );

  // CPU clock and two free-running oscillators; every oscillator edge lands on a falling CPU clock edge.
  always #5 clk_i = ~clk_i;
  always #40 hf_i = ~hf_i;
  always #(LF_HALF) lf_i = ~lf_i;

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One APB transfer; it waits for pready, so any number of wait states is fine.
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Lets one edge pass and waits for its updates to land before sampling.
  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    wrap_up;
  end

  // Main sequence: reset state, plain levels, floating, timer clock, buzzer, bad address.
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    settle;
    chk(pin_oe_o[15:0], 16'h0);
    chk(pin_o[19:16], 4'h3);
    chk(pin_oe_b[15:0], 16'h8000);
    chk(pin_b[19:16], 4'hF);
    @(posedge clk_i) serial_ready_out_i <= 1'b1;
    settle;
    chk(pin_b[15], 1'b1);
    @(posedge clk_i) serial_ready_out_i <= 1'b0;
    settle;
    chk(pin_b[15], 1'b0);
    apb(IDX_GROUP4, 1'b0, 32'h0);
    chk(rdata, 32'hF);
    apb(IDX_FLOAT, 1'b0, 32'h0);
    chk(rdata, 32'h0);
    apb(IDX_FLOAT, 1'b1, 32'hF);
    apb(IDX_TIMER, 1'b1, 32'h0);
    // Level checked one step after the completing edge, so a late update shows.
    for (int g = 0; g < 4; g++) begin
      apb(IDX_GROUP0 + 12'(g), 1'b1, {28'h0, pat[g]});
      #1;
      chk(level_o[g*4 +: 4], pat[g]);
      apb(IDX_GROUP0 + 12'(g), 1'b0, 32'h0);
      chk(rdata, {28'h0, pat[g]});
    end
    chk(pin_oe_o[7:4], 4'(~pat[1]));
    chk(pin_o[15], 1'b0);
    apb(IDX_FLOAT, 1'b1, 32'hA);
    #1;
    chk(pin_oe_o[15:0], 16'hF0A0);
    apb(IDX_FLOAT, 1'b1, 32'hF);
    apb(IDX_TIMER, 1'b1, 32'hD);
    #1;
    chk(tsel_o, 3'h5);
    @(posedge clk_i) tclk_i <= 1'b1;
    settle;
    chk(pin_o[15], 1'b1);
    @(posedge clk_i) tclk_i <= 1'b0;
    settle;
    chk(pin_o[15], 1'b0);
    apb(IDX_GROUP3, 1'b1, 32'hE);
    #1;
    chk(pin_o[15], 1'b1);
    apb(IDX_TIMER, 1'b1, 32'h5);
    apb(IDX_GROUP3, 1'b1, 32'h6);
    tclk_i <= 1'b1;
    settle;
    chk(pin_o[15], 1'b0);
    apb(IDX_GROUP4, 1'b1, 32'h7);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i) buzzer_i <= b[0];
      settle;
      chk(pin_o[19:18], {b[0], ~b[0]});
    end
    apb(IDX_GROUP4, 1'b1, 32'h3);
    apb(IDX_GROUP4, 1'b0, 32'h0);
    chk(rdata, 32'h3);
    buzzer_i <= 1'b1;
    settle;
    chk(pin_o[19:18], 2'b10);
    apb(IDX_GROUP4, 1'b1, 32'hB);
    #1;
    chk(pin_o[19:16], 4'h3);
    // Clock pair on the second build: slow clock halved, so one period is four slow half periods.
    apb(IDX_GROUP4, 1'b1, 32'hA);
    @(posedge pin_b[18]);
    t0 = $time;
    #1;
    chk(pin_b[16], 1'b0);
    repeat (3 * LF_HALF / 10) @(posedge clk_i);
    #1;
    chk(pin_b[18], 1'b0);
    chk(pin_b[16], 1'b1);
    @(posedge pin_b[18]);
    chk(32'(($time - t0) / 10), 4 * LF_HALF / 10);
    apb(IDX_GROUP4, 1'b1, 32'hF);
    #1;
    chk(pin_b[19:16], 4'hF);
    apb(12'hF60, 1'b0, 32'h0);
    chk(rdata, 32'h0);
    chk(rerr, 1'b1);
    wrap_up;
  end
endmodule

// [design/opsf_clkdiv.sv]
// Build-time selected clock-output source: fast oscillator or divided slow oscillator.
module opsf_clkdiv import opsf_pkg::*; #(
  parameter logic [3:0] CLK_SRC = 4'h1
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic hf_i,
  input  wire logic lf_i,
  output logic      clk_out_o
);

  typedef struct packed {
    logic       lf_prev;
    logic [6:0] cnt;
    logic       out;
  } opsf_div_t;

  opsf_div_t st_r;
  opsf_div_t st_nxt;

  // Counter bit used for the divided sources; clamped so that the branch kept for the
  // undivided sources still names a real bit of the counter.
  localparam int unsigned DIV_TAP = (CLK_SRC > 4'h1) ? 32'(CLK_SRC - 4'h2) : 32'd0;

  // Count slow-clock rising edges; counter bit k toggles at the slow rate over 2**(k+1).
  always_comb begin
    st_nxt         = st_r;
    st_nxt.lf_prev = lf_i;
    if (lf_i && !st_r.lf_prev) begin
      st_nxt.cnt = st_r.cnt + 7'h01;
    end
    if (CLK_SRC == CLK_SRC_HF) begin
      st_nxt.out = hf_i;
    end else if (CLK_SRC == 4'h1) begin
      st_nxt.out = lf_i;
    end else begin
      st_nxt.out = st_r.cnt[DIV_TAP];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_out_o = st_r.out;

endmodule

// [design/opsf_pkg.sv]
// Constants, register map and option codes for the special-function output port.
package opsf_pkg;

  localparam int unsigned PADDR_W = 14;

  // Register indices as printed; byte address is four times the index.
  localparam logic [11:0] IDX_GROUP0   = 12'hF50;
  localparam logic [11:0] IDX_GROUP1   = 12'hF51;
  localparam logic [11:0] IDX_GROUP2   = 12'hF52;
  localparam logic [11:0] IDX_GROUP3   = 12'hF53;
  localparam logic [11:0] IDX_GROUP4   = 12'hF54;
  localparam logic [11:0] IDX_TIMER    = 12'hF79;
  localparam logic [11:0] IDX_FLOAT    = 12'hF7B;

  // Field positions.
  localparam int unsigned TMR_EN_BIT   = 3;
  localparam int unsigned TMR_SEL_LSB  = 0;
  localparam int unsigned G3_SPECIAL   = 15;
  localparam int unsigned G4_INV_CLK   = 16;
  localparam int unsigned G4_SPECIAL   = 18;
  localparam int unsigned G4_BUZZER    = 19;

  // Values after reset.
  localparam logic [3:0] GROUP4_RST    = 4'hF;
  localparam logic [3:0] FLOAT_RST     = 4'h0;
  localparam logic       TMR_EN_RST    = 1'h0;
  localparam logic [2:0] TMR_SEL_RST   = 3'h0;

  // Low-frequency oscillator rate in Hz and the slowest divider output.
  localparam int unsigned LF_OSC_HZ    = 32768;
  localparam int unsigned LF_MAX_DIV   = 128;

  // Build options for group3_bit3.
  typedef enum logic [1:0] {
    OPSF_G3_LEVEL = 2'h0,
    OPSF_G3_SERIAL_READY_OUT  = 2'h1,
    OPSF_G3_TCLK  = 2'h2
  } opsf_g3_opt_t;

  // Build options for group4_bit2.
  typedef enum logic [1:0] {
    OPSF_G42_LEVEL = 2'h0,
    OPSF_G42_IBUZ  = 2'h1,
    OPSF_G42_CLK   = 2'h2
  } opsf_g42_opt_t;

  // Clock-output source: 0 high-frequency, n = 1..8 low clock divided by 2**(n-1).
  localparam logic [3:0] CLK_SRC_HF    = 4'h0;

endpackage

// [design/opsf_port.sv]
// Twenty-bit output port with APB registers and build-time special pin functions.
//
// The APB slave port is this design's own decision.
module opsf_port import opsf_pkg::*; #(
  parameter opsf_g3_opt_t  G3_OPT       = OPSF_G3_LEVEL,
  parameter logic          G3_TWO_STATE = 1'b0,
  parameter logic          G4_BUZZ_OPT  = 1'b0,
  parameter opsf_g42_opt_t G42_OPT      = OPSF_G42_LEVEL,
  parameter logic          G40_ICLK_OPT = 1'b0,
  parameter logic [3:0]    CLK_SRC      = 4'h1,
  parameter logic [19:0]   OPEN_DRAIN   = 20'h00000
) (
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               buzzer_i,
  input  wire logic               serial_ready_i,
  input  wire logic               timer_clock_i,
  output logic      [2:0]         timer_clock_select_o,
  input  wire logic               high_freq_osc_clock_i,
  input  wire logic               low_freq_osc_clock_i,
  output logic      [19:0]        pin_o,
  output logic      [19:0]        pin_oe_o
);

  typedef struct packed {
    logic [4:0][3:0] data;
    logic [3:0]      flt;
    logic            tmr_en;
    logic [2:0]      tmr_sel;
    logic [31:0]     rdata;
  } opsf_state_t;

  opsf_state_t st_r;
  opsf_state_t st_nxt;

  logic [1:0]  osc_sync;
  logic        div_clk;
  logic [11:0] idx;
  logic        hit;
  logic        setup;
  logic        access;
  logic [31:0] rd_val;
  logic [19:0] lvl;
  logic [19:0] drive;

  // Oscillators come from outside this clock domain.
  opsf_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({high_freq_osc_clock_i, low_freq_osc_clock_i}),
    .sync_o   (osc_sync)
  );

  // The divider registers the oscillator it samples, so its output is glitch free here
  // while the pad itself can still show a short pulse when a data bit toggles.
  opsf_clkdiv #(
    .CLK_SRC (CLK_SRC)
  ) u_clkdiv (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .hf_i      (osc_sync[1]),
    .lf_i      (osc_sync[0]),
    .clk_out_o (div_clk)
  );

  // Address decode: word aligned, index is the upper address bits.
  assign idx    = paddr_i[PADDR_W-1:2];
  assign setup  = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign hit    = (paddr_i[1:0] == 2'h0) &&
                  (idx == IDX_GROUP0 || idx == IDX_GROUP1 || idx == IDX_GROUP2 ||
                   idx == IDX_GROUP3 || idx == IDX_GROUP4 || idx == IDX_TIMER || idx == IDX_FLOAT);

  // Read mux; every data bit reads back, including group4_bit2 as plain storage.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_GROUP0: rd_val[3:0] = st_r.data[0];
      IDX_GROUP1: rd_val[3:0] = st_r.data[1];
      IDX_GROUP2: rd_val[3:0] = st_r.data[2];
      IDX_GROUP3: rd_val[3:0] = st_r.data[3];
      IDX_GROUP4: rd_val[3:0] = st_r.data[4];
      IDX_TIMER: begin
        rd_val[TMR_EN_BIT]               = st_r.tmr_en;
        rd_val[TMR_SEL_LSB +: 3]         = st_r.tmr_sel;
      end
      IDX_FLOAT:  rd_val[3:0] = st_r.flt;
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  // Writes land at the access edge; read data is captured in the setup cycle
  // so that it is a flop output without needing a wait state.
  always_comb begin
    st_nxt = st_r;
    if (setup) begin
      st_nxt.rdata = hit ? rd_val : 32'h0000_0000;
    end
    if (access && pwrite_i && hit) begin
      case (idx)
        IDX_GROUP0: st_nxt.data[0] = pwdata_i[3:0];
        IDX_GROUP1: st_nxt.data[1] = pwdata_i[3:0];
        IDX_GROUP2: st_nxt.data[2] = pwdata_i[3:0];
        IDX_GROUP3: st_nxt.data[3] = pwdata_i[3:0];
        IDX_GROUP4: st_nxt.data[4] = pwdata_i[3:0];
        IDX_TIMER: begin
          st_nxt.tmr_en  = pwdata_i[TMR_EN_BIT];
          st_nxt.tmr_sel = pwdata_i[TMR_SEL_LSB +: 3];
        end
        IDX_FLOAT:  st_nxt.flt = pwdata_i[3:0];
        default:    st_nxt.flt = st_r.flt;
      endcase
    end
  end

  // Groups zero to three are deliberately left out of reset, so their read data, and their plain
  // pins once the float controls enable them, are undefined until software writes them.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r.data[4] <= GROUP4_RST;
      st_r.flt     <= FLOAT_RST;
      st_r.tmr_en  <= TMR_EN_RST;
      st_r.tmr_sel <= TMR_SEL_RST;
      st_r.rdata   <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready_o             = 1'b1;
  assign pslverr_o            = access && !hit;
  assign prdata_o             = st_r.rdata;
  assign timer_clock_select_o = st_r.tmr_sel;

  // Pin levels: plain register bits unless a special function is built in.
  always_comb begin
    lvl = {st_r.data[4], st_r.data[3], st_r.data[2], st_r.data[1], st_r.data[0]};
    case (G3_OPT)
      OPSF_G3_SERIAL_READY_OUT: lvl[G3_SPECIAL] = serial_ready_i;
      OPSF_G3_TCLK: begin
        if (st_r.tmr_en) begin
          lvl[G3_SPECIAL] = st_r.data[3][3] | timer_clock_i;
        end else begin
          lvl[G3_SPECIAL] = st_r.data[3][3];
        end
      end
      default:      lvl[G3_SPECIAL] = st_r.data[3][3];
    endcase
    if (G4_BUZZ_OPT) begin
      lvl[G4_BUZZER] = !st_r.data[4][3] && buzzer_i;
    end
    case (G42_OPT)
      OPSF_G42_IBUZ: lvl[G4_SPECIAL] = !st_r.data[4][3] && !buzzer_i;
      OPSF_G42_CLK:  lvl[G4_SPECIAL] = st_r.data[4][2] | div_clk;
      default:       lvl[G4_SPECIAL] = st_r.data[4][2];
    endcase
    if (G40_ICLK_OPT) begin
      lvl[G4_INV_CLK] = st_r.data[4][0] | !div_clk;
    end
  end

  // Per-pin driver: float control on pins 0 to 15 (pins 16 to 19 always driven), then push-pull or open-drain stage.
  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_pin
      if (gi < 16) begin : g_flt
        if (gi == G3_SPECIAL) begin : g_g3
          assign drive[gi] = st_r.flt[gi/4] || G3_TWO_STATE;
        end else begin : g_plain
          assign drive[gi] = st_r.flt[gi/4];
        end
      end else begin : g_fixed
        assign drive[gi] = 1'b1;
      end
      // Open-drain pins only pull low; the level output is then always zero.
      assign pin_oe_o[gi] = drive[gi] && (!OPEN_DRAIN[gi] || !lvl[gi]);
      assign pin_o[gi]    = drive[gi] && !OPEN_DRAIN[gi] && lvl[gi];
    end
  endgenerate

  // Checks on the register path and on the pin functions.
  write_lands_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (access && pwrite_i && paddr_i == {IDX_GROUP1, 2'h0})
      |=> (st_r.data[1] == $past(pwdata_i[3:0])) && (lvl[7:4] == $past(pwdata_i[3:0])))
    else $error("group one write did not reach the pin level");

  float_group_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !st_r.flt[0] |-> pin_oe_o[3:0] == 4'h0)
    else $error("floated group zero is still driven");

  read_back_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (setup && !pwrite_i && paddr_i == {IDX_GROUP4, 2'h0}) ##1 access
      |-> prdata_o[3:0] == st_r.data[4])
    else $error("group four read data does not match the register");

  buzz_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G4_BUZZ_OPT && st_r.data[4][3]) |-> !lvl[G4_BUZZER] && (G42_OPT != OPSF_G42_IBUZ || !lvl[G4_SPECIAL]))
    else $error("buzzer pins not low while gated off");

  buzz_pair_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G4_BUZZ_OPT && G42_OPT == OPSF_G42_IBUZ && !st_r.data[4][3])
      |-> lvl[G4_BUZZER] != lvl[G4_SPECIAL])
    else $error("buzzer and inverted buzzer not complementary");

  clk_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G42_OPT == OPSF_G42_CLK && st_r.data[4][2]) |-> lvl[G4_SPECIAL])
    else $error("clock pin not held high while off");

  clk_anti_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G42_OPT == OPSF_G42_CLK && G40_ICLK_OPT && !st_r.data[4][2] && !st_r.data[4][0])
      |-> lvl[G4_INV_CLK] != lvl[G4_SPECIAL])
    else $error("inverted clock pin not in antiphase");

  timer_dc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G3_OPT == OPSF_G3_TCLK && !st_r.tmr_en) |-> lvl[G3_SPECIAL] === st_r.data[3][3])
    else $error("timer pin not a level output while disabled");

  timer_on_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G3_OPT == OPSF_G3_TCLK && st_r.tmr_en && !st_r.data[3][3]) |-> lvl[G3_SPECIAL] == timer_clock_i)
    else $error("timer clock not passed to the pin");

  unmapped_err_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (access && !hit) |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Reset values, register writes and each special-pin build option except the inverted clock and the plain group3_bit3 and group4_bit2 levels.
  // Groups zero to three hold unknown data until written, so pin comparisons on them match exactly.
  float_reset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i) |-> st_r.flt == FLOAT_RST)
    else $error("float controls not cleared by reset");

  group4_reset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i) |-> st_r.data[4] == GROUP4_RST)
    else $error("group four data not set by reset");

  flt_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (access && pwrite_i && paddr_i == {IDX_FLOAT, 2'h0})
      |=> st_r.flt == $past(pwdata_i[3:0]))
    else $error("float control write did not land");

  tmr_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (access && pwrite_i && paddr_i == {IDX_TIMER, 2'h0})
      |=> timer_clock_select_o == $past(pwdata_i[TMR_SEL_LSB +: 3])
          && st_r.tmr_en == $past(pwdata_i[TMR_EN_BIT]))
    else $error("timer control write did not land");

  read_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    access |-> prdata_o[31:4] == 28'h0000000)
    else $error("read data has bits above the four-bit register");

  plain_level_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_r.flt[2]
      |-> pin_o[11:8] === (st_r.data[2] & ~OPEN_DRAIN[11:8]))
    else $error("group two pins do not follow their data bits");

  float_drive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_r.flt == 4'hF)
      |-> (pin_oe_o[15:0] | OPEN_DRAIN[15:0]) == 16'hFFFF)
    else $error("enabled group not driven");

  od_low_only_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (pin_o & OPEN_DRAIN) == 20'h00000)
    else $error("open-drain pin driven high");

  two_state_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G3_TWO_STATE && !OPEN_DRAIN[G3_SPECIAL]) |-> pin_oe_o[G3_SPECIAL])
    else $error("two-state pin released by its float control");

  serial_ready_out_pass_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G3_OPT == OPSF_G3_SERIAL_READY_OUT) |-> lvl[G3_SPECIAL] == serial_ready_i)
    else $error("serial ready level not on its pin");

  timer_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G3_OPT == OPSF_G3_TCLK && st_r.tmr_en && st_r.data[3][3])
      |-> lvl[G3_SPECIAL])
    else $error("timer clock pin not held high while off");

  g4_plain_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !G4_BUZZ_OPT
      |-> lvl[G4_BUZZER] == st_r.data[4][3] && lvl[G4_SPECIAL - 1] == st_r.data[4][1])
    else $error("plain group four pin does not follow its data bit");

  buzz_emit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G4_BUZZ_OPT && !st_r.data[4][3]) |-> lvl[G4_BUZZER] == buzzer_i)
    else $error("buzzer signal not on its pin while enabled");

  ibuz_store_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G42_OPT == OPSF_G42_IBUZ && $changed(st_r.data[4][2]) && $stable(st_r.data[4][3]) && $stable(buzzer_i))
      |-> $stable(lvl[G4_SPECIAL]))
    else $error("storage bit reached the inverted buzzer pin");

  clk_emit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (G42_OPT == OPSF_G42_CLK && !st_r.data[4][2])
      |-> lvl[G4_SPECIAL] == div_clk)
    else $error("clock not on its pin while enabled");

endmodule

// [design/opsf_sync.sv]
// Two-flop synchroniser for oscillator levels entering the CPU clock domain.
module opsf_sync import opsf_pkg::*; #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } opsf_sync_t;

  opsf_sync_t st_r;
  opsf_sync_t st_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    st_nxt.meta   = async_i;
    st_nxt.stable = st_r.meta;
  end

  // Both stages reset to a quiet low level.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.stable;

endmodule
